// ==== core/swt_pkg.sv ====
package swt_pkg;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_CONFIG     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS     = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h10;
  // command bits of the control register
  localparam int          CTRL_INIT_BIT   = 0;
  localparam int          CTRL_BEGIN_BIT  = 1;
  localparam int          CTRL_RELOAD_BIT = 2;
  localparam int          CTRL_HALT_BIT   = 3;
  // configuration fields
  localparam int          CFG_TICK_LSB    = 0;
  localparam int          CFG_UNIT_LSB    = 16;
  // status fields
  localparam int          ST_INIT_BIT     = 0;
  localparam int          ST_RUN_BIT      = 1;
  localparam int          ST_OK_BIT       = 2;
  localparam int          ST_EXP_BIT      = 3;
  localparam int          ST_REMAIN_LSB   = 16;
  // interrupt status and mask layout
  localparam int          IRQ_EXP_BIT     = 0;
  localparam int          IRQ_FAIL_BIT    = 1;
  localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;
  // timeout defaults and unit codes
  localparam logic [15:0] DEFAULT_TICKS   = 16'h00ff;
  localparam logic [7:0]  UNIT_MINUTE     = 8'h00;
  localparam logic [7:0]  UNIT_SECOND     = 8'h01;
  localparam logic [7:0]  DEFAULT_UNIT    = UNIT_SECOND;
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned TICK_SEC_S      = 1;
  localparam int unsigned CYC_PER_SEC     = TICK_SEC_S * (1000000000 / CLK_PERIOD_NS);
  localparam int unsigned SEC_PER_MIN     = 60;
  localparam int unsigned SYSRST_NS       = 1000;
  localparam int unsigned SYSRST_CYC      = (SYSRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SYSRST_LOAD     = 8'(SYSRST_CYC);
  // bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ==== core/swt_tick_base.sv ====
`timescale 1ns/1ps
// free-running time base: second and minute pulses plus blink phase
module swt_tick_base #(
  parameter int unsigned CYC_PER_SEC = swt_pkg::CYC_PER_SEC,
  parameter int unsigned SEC_PER_MIN = swt_pkg::SEC_PER_MIN
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      sec_tick,
  output logic      min_tick,
  output logic      blink
);
  localparam int CW = $clog2(CYC_PER_SEC);
  localparam int MW = $clog2(SEC_PER_MIN);

  // refuse counts the counters cannot serve
  if (CYC_PER_SEC < 2 || SEC_PER_MIN < 2) begin : g_bad
    $error("swt_tick_base: counts must be at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] cyc;   // cycles within the current second
    logic [MW-1:0] sec;   // seconds within the current minute
    logic          sp;    // second pulse
    logic          mp;    // minute pulse
    logic          bl;    // blink phase
  } swt_tick_state_t;

  swt_tick_state_t s;
  swt_tick_state_t next_s;

  // counters wrap freely; a watchdog started mid-second sees a short first tick
  always_comb begin
    next_s    = s;
    next_s.sp = 1'b0;
    next_s.mp = 1'b0;
    if (s.cyc == CW'(CYC_PER_SEC - 1)) begin
      next_s.cyc = '0;
      next_s.sp  = 1'b1;
      next_s.bl  = ~s.bl;
      if (s.sec == MW'(SEC_PER_MIN - 1)) begin
        next_s.sec = '0;
        next_s.mp  = 1'b1;
      end else begin
        next_s.sec = s.sec + MW'(1);
      end
    end else begin
      next_s.cyc = s.cyc + CW'(1);
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sec_tick = s.sp;
  assign min_tick = s.mp;
  assign blink    = s.bl;
endmodule // swt_tick_base

// ==== core/swt_watchdog.sv ====
`timescale 1ns/1ps
module swt_watchdog #(
  parameter int unsigned CYC_PER_SEC = swt_pkg::CYC_PER_SEC,
  parameter int unsigned SEC_PER_MIN = swt_pkg::SEC_PER_MIN
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             system_reset,
  output logic             watchdog_indicator
);
  // refuse a time base too short to count
  if (CYC_PER_SEC < 2) begin : g_bad
    $error("swt_watchdog: CYC_PER_SEC must be at least 2");
  end

  // whole block state; outputs are fields of it, so every output is a flop
  typedef struct packed {
    // bus side: held write halves and channel flags
    logic        aw_full;   // write address held
    logic [7:0]  aw_addr;
    logic        w_full;    // write data held
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    // watchdog side
    logic        init_done; // initialise seen
    logic        running;   // countdown active
    logic        ok;        // result of last request
    logic        expired;   // sticky: an expiry happened
    logic [7:0]  unit;      // tick unit code
    logic [15:0] ticks;     // programmed timeout
    logic [15:0] remain;    // countdown value
    // interrupt bookkeeping and pin drives
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        irq;
    logic [7:0]  rst_cnt;   // system reset stretch
    logic        sys_rst;
    logic        ind;       // indicator drive
  } swt_state_t;

  swt_state_t  s;          // registered state
  swt_state_t  next_s;     // next state
  logic        sec_tick;   // one-second pulse
  logic        min_tick;   // one-minute pulse
  logic        blink;      // blink phase
  logic        do_wr;      // write executes this cycle
  logic        do_rd;      // read accepted this cycle
  logic        wr_hit;     // write address is mapped
  logic        do_init;
  logic        do_begin;
  logic        do_reload;
  logic        do_halt;
  logic        do_cfg;
  logic        cfg_ok;     // configure request acceptable
  logic        cnt_tick;   // tick of the selected unit
  logic        wr_ctl;     // any command overrides the countdown
  logic        do_expire;
  logic [31:0] cfg_new;    // configuration after byte lanes
  logic [1:0]  ev;         // interrupt events this cycle
  logic [1:0]  rd_clr;     // interrupt bits cleared by read

  // time base shared by countdown and blinking
  swt_tick_base #(
    .CYC_PER_SEC (CYC_PER_SEC),
    .SEC_PER_MIN (SEC_PER_MIN)
  ) u_tick (
    .clk      (clk),
    .rst      (rst),
    .sec_tick (sec_tick),
    .min_tick (min_tick),
    .blink    (blink)
  );

  // read data mux, from registered state
  function automatic logic [31:0] rd_mux(input swt_state_t st, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      swt_pkg::ADDR_CONFIG: begin
        d[swt_pkg::CFG_TICK_LSB +: 16] = st.ticks;
        d[swt_pkg::CFG_UNIT_LSB +: 8]  = st.unit;
      end
      swt_pkg::ADDR_STATUS: begin
        d[swt_pkg::ST_INIT_BIT]          = st.init_done;
        d[swt_pkg::ST_RUN_BIT]           = st.running;
        d[swt_pkg::ST_OK_BIT]            = st.ok;
        d[swt_pkg::ST_EXP_BIT]           = st.expired;
        d[swt_pkg::ST_REMAIN_LSB +: 16]  = st.remain;
      end
      swt_pkg::ADDR_IRQ_STAT: d[1:0] = st.irq_stat;
      swt_pkg::ADDR_IRQ_MASK: d[1:0] = st.irq_mask;
      default:                d = 32'h0000_0000; // control reads as zero
    endcase
    return d;
  endfunction

  // mapped address check
  function automatic logic mapped(input logic [7:0] a);
    return a == swt_pkg::ADDR_CTRL || a == swt_pkg::ADDR_CONFIG || a == swt_pkg::ADDR_STATUS ||
           a == swt_pkg::ADDR_IRQ_STAT || a == swt_pkg::ADDR_IRQ_MASK;
  endfunction

  // all next-state logic
  always_comb begin
    next_s = s;
    ev     = 2'h0;
    rd_clr = 2'h0;
    // write channel handshakes; address and data taken in either order
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // a write executes once both halves are held and the previous answer is gone
    do_wr  = s.aw_full && s.w_full && !s.bvalid;
    wr_hit = mapped(s.aw_addr);
    // commands need byte lane 0; priority init, halt, begin, reload
    do_init   = do_wr && s.aw_addr == swt_pkg::ADDR_CTRL && s.w_strb[0] &&
                s.w_data[swt_pkg::CTRL_INIT_BIT];
    do_halt   = do_wr && s.aw_addr == swt_pkg::ADDR_CTRL && s.w_strb[0] && !do_init &&
                s.w_data[swt_pkg::CTRL_HALT_BIT];
    do_begin  = do_wr && s.aw_addr == swt_pkg::ADDR_CTRL && s.w_strb[0] && !do_init && !do_halt &&
                s.w_data[swt_pkg::CTRL_BEGIN_BIT];
    do_reload = do_wr && s.aw_addr == swt_pkg::ADDR_CTRL && s.w_strb[0] && !do_init && !do_halt &&
                !do_begin && s.w_data[swt_pkg::CTRL_RELOAD_BIT];
    wr_ctl    = do_init || do_halt || do_begin || do_reload;
    // a configure write is taken whatever the lanes; refused values change nothing
    do_cfg    = do_wr && s.aw_addr == swt_pkg::ADDR_CONFIG;
    // merge byte lanes into the current configuration
    cfg_new = {8'h00, s.unit, s.ticks};
    for (int i = 0; i < 3; i++) begin
      if (s.w_strb[i]) begin
        cfg_new[8*i +: 8] = s.w_data[8*i +: 8];
      end
    end
    cfg_ok = cfg_new[swt_pkg::CFG_UNIT_LSB +: 8] <= swt_pkg::UNIT_SECOND &&
             cfg_new[swt_pkg::CFG_TICK_LSB +: 16] != 16'h0000;
    // countdown on the selected unit; a command in the same cycle wins
    cnt_tick  = (s.unit == swt_pkg::UNIT_MINUTE) ? min_tick : sec_tick;
    do_expire = s.running && cnt_tick && !wr_ctl && s.remain == 16'h0001;
    // the reset stretch runs down on its own and nothing freezes it, but a
    // later expiry reloads it to SYSRST_LOAD and so lengthens the pulse
    if (s.rst_cnt != 8'h00) begin
      next_s.rst_cnt = s.rst_cnt - 8'h01;
    end
    if (s.running && cnt_tick && !wr_ctl) begin
      if (do_expire) begin
        next_s.running = 1'b0;
        next_s.expired = 1'b1;
        next_s.remain  = 16'h0000;
        next_s.rst_cnt = swt_pkg::SYSRST_LOAD;
        ev[swt_pkg::IRQ_EXP_BIT] = 1'b1;
      end else begin
        next_s.remain = s.remain - 16'h0001;
      end
    end
    // register writes and commands
    if (do_wr) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = wr_hit ? swt_pkg::RESP_OKAY : swt_pkg::RESP_SLVERR;
    end
    // initialise also stops a running countdown
    if (do_init) begin
      next_s.init_done = 1'b1;
      next_s.ticks     = swt_pkg::DEFAULT_TICKS;
      next_s.unit      = swt_pkg::DEFAULT_UNIT;
      next_s.running   = 1'b0;
      next_s.ok        = 1'b1;
    end
    if (do_halt) begin
      next_s.running = 1'b0;
      next_s.ok      = 1'b1;
    end
    if (do_begin) begin
      // a timeout is in place only once initialise has loaded one
      next_s.running = s.init_done;
      next_s.remain  = s.ticks;
      next_s.ok      = s.init_done;
      ev[swt_pkg::IRQ_FAIL_BIT] = !s.init_done;
    end
    if (do_reload) begin
      next_s.remain = s.ticks;
      next_s.ok     = 1'b1;
    end
    if (do_cfg) begin
      // a refused configuration leaves the previous timeout in force
      next_s.ok = cfg_ok;
      ev[swt_pkg::IRQ_FAIL_BIT] = !cfg_ok;
      if (cfg_ok) begin
        next_s.ticks = cfg_new[swt_pkg::CFG_TICK_LSB +: 16];
        next_s.unit  = cfg_new[swt_pkg::CFG_UNIT_LSB +: 8];
      end
    end
    // mask write; status and interrupt status writes are answered and ignored
    if (do_wr && s.aw_addr == swt_pkg::ADDR_IRQ_MASK && s.w_strb[0]) begin
      next_s.irq_mask = s.w_data[1:0];
    end
    // read channel: one cycle from address to data
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    do_rd = s.arready && s_axi_arvalid;
    if (do_rd) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_mux(s, s_axi_araddr);
      next_s.rresp  = mapped(s_axi_araddr) ? swt_pkg::RESP_OKAY : swt_pkg::RESP_SLVERR;
      if (s_axi_araddr == swt_pkg::ADDR_IRQ_STAT) begin
        rd_clr = s.irq_stat;
      end
    end
    // an event in the clearing cycle survives the read
    next_s.irq_stat = (s.irq_stat & ~rd_clr) | ev;
    next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);
    // ready flags follow the held halves so a taken item is never overwritten
    next_s.awready  = !next_s.aw_full;
    next_s.wready   = !next_s.w_full;
    next_s.arready  = !next_s.rvalid;
    next_s.sys_rst  = next_s.rst_cnt != 8'h00;
    next_s.ind      = next_s.running && blink;
  end

  // state register; reset leaves the watchdog uninitialised and idle
  always_ff @(posedge clk) begin
    if (rst) begin
      s          <= '0;
      s.ticks    <= swt_pkg::DEFAULT_TICKS;
      s.unit     <= swt_pkg::DEFAULT_UNIT;
      s.irq_mask <= swt_pkg::IRQ_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs are plain fields of the state register, no logic after the flops
  assign s_axi_awready      = s.awready;
  assign s_axi_wready       = s.wready;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_arready      = s.arready;
  assign s_axi_rvalid       = s.rvalid;
  assign s_axi_rdata        = s.rdata;
  assign s_axi_rresp        = s.rresp;
  assign irq                = s.irq;
  assign system_reset       = s.sys_rst;
  assign watchdog_indicator = s.ind;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // request results and countdown
  AST_DEFAULT_LOAD: assert property (do_init |=> s.ticks == 16'h00ff && s.unit == 8'h01)
    else $error("initialise did not load the default timeout");
  AST_TICKS_NONZERO: assert property (s.ticks != 16'h0000)
    else $error("programmed timeout became zero");
  AST_UNIT_MINUTE: assert property (s.running && s.unit == 8'h00 && !min_tick && !wr_ctl |=>
                                    $stable(s.remain))
    else $error("minute countdown moved without a minute tick");
  AST_CFG_RESULT: assert property (do_cfg |=> s.ok == $past(cfg_ok) &&
                                   (s.ok || $stable(s.ticks)))
    else $error("configure result or refusal wrong");
  AST_INDICATOR: assert property (s.ind |-> s.running)
    else $error("indicator active while stopped");
  AST_EXPIRE: assert property (do_expire |=> system_reset && !s.running ##1 system_reset)
    else $error("expiry did not reset the system");
  AST_RELOAD: assert property (do_reload |=> s.remain == $past(s.ticks) && s.ok)
    else $error("reload did not restore the timeout");
  AST_HALT: assert property (do_halt |=> !s.running && !s.ind && s.ok ##1 !s.sys_rst ||
                             $past(s.rst_cnt) != 8'h00)
    else $error("halt did not stop the countdown");
  AST_BEGIN: assert property (do_begin |=> s.running == $past(s.init_done) &&
                              s.ok == $past(s.init_done))
    else $error("begin result mismatch");
  AST_DECREMENT: assert property (s.running && cnt_tick && !wr_ctl && s.remain > 16'h0001 |=>
                                  s.remain == $past(s.remain) - 16'h0001)
    else $error("countdown did not step by one");

  // begin load, interrupt events and the reset stretch
  AST_BEGIN_LOAD: assert property (do_begin && s.init_done |=> s.running &&
                                   s.remain == $past(s.ticks))
    else $error("begin did not load the programmed timeout");
  AST_FAIL_EVENT: assert property ((do_cfg && !cfg_ok) || (do_begin && !s.init_done) |=>
                                   s.irq_stat[swt_pkg::IRQ_FAIL_BIT])
    else $error("refused request left no failure event");
  AST_EXPIRE_EVENT: assert property (do_expire |=> s.irq_stat[swt_pkg::IRQ_EXP_BIT] && s.expired)
    else $error("expiry left no event or sticky flag");
  // the stretch counter itself is checked, so no long repetition is needed
  AST_STRETCH: assert property (s.rst_cnt != 8'h00 && !do_expire |=>
                                s.rst_cnt == $past(s.rst_cnt) - 8'h01)
    else $error("system reset stretch did not count down");

  // main scenarios the bench should reach
  COV_BEGIN:  cover property (do_begin && s.init_done);
  COV_EXPIRE: cover property (do_expire);
  COV_RELOAD: cover property (s.running ##1 do_reload);
  COV_CFGBAD: cover property (do_cfg && !cfg_ok);
  COV_HALT:   cover property (s.running ##1 do_halt);
endmodule // swt_watchdog

// ==== testbench/swt_watchdog_tb_top.sv ====
`timescale 1ns/1ps
// self-checking bench for the watchdog, driven over its register bus
module swt_watchdog_tb_top;
  localparam int CPS = 10; // shortened second keeps the run short
  localparam int SPM = 3;  // shortened minute, in seconds
  logic        clk, rst;              // clock and synchronous reset
  logic [7:0]  awaddr, araddr;        // bus addresses
  logic        awvalid, wvalid, bready; // write handshakes
  logic        arvalid, rready;       // read handshakes
  logic [31:0] wdata, rdata;          // bus data
  logic [3:0]  wstrb;                 // byte lanes
  logic        awready, wready, bvalid, arready, rvalid; // slave handshakes
  logic [1:0]  bresp, rresp;          // bus responses
  logic        irq, sys_rst, ind;     // block outputs
  logic [1:0]  r;                     // last response
  logic [31:0] d;                     // last read word
  int          err_count, samples_checked;
  bit          rst_seen, ind_seen;    // activity seen by monitors
  int          ind_rises;             // indicator rising edges seen
  logic        ind_q;                 // indicator one edge ago
  int          t, u, k;               // scenario scratch

  swt_watchdog #(.CYC_PER_SEC(CPS), .SEC_PER_MIN(SPM)) i_swt_watchdog (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .system_reset(sys_rst),
    .watchdog_indicator(ind));

  // free-running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // monitors: any reset pulse or indicator high is latched for later checks
  always @(posedge clk) begin
    if (sys_rst === 1'b1) rst_seen = 1'b1;
    if (ind === 1'b1) ind_seen = 1'b1;
    if (ind === 1'b1 && ind_q === 1'b0) ind_rises++;
    ind_q = ind;
  end

  // prints the verdict and ends the run
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one comparison; the caller has already reduced it to a single bit
  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
    int n;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= dat; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 200) begin
      chk(1'b0, "write hang");
      close_out;
    end
  endtask

  // read: rready held from the start until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        dat = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 200) begin
      chk(1'b0, "read hang");
      close_out;
    end
  endtask

  // issue one command bit of the control register
  task automatic cmd(input int bitpos);
    wr(swt_pkg::ADDR_CTRL, 32'h1 << bitpos, r);
  endtask

  // configure acceptance expected from count and unit
  function automatic bit cfg_ok(input int tk, input int un);
    return (un <= 1) && (tk != 0);
  endfunction

  // waits for expiry inside the window that t ticks of per cycles allow, then times the pulse
  task automatic expire(input int tt, input int per);
    int n, hi;
    for (n = 0; n < tt * per + 6 && sys_rst !== 1'b1; n++) @(posedge clk);
    chk(sys_rst === 1'b1 && n >= (tt - 1) * per - 2, "expiry time");
    hi = 0;
    while (sys_rst === 1'b1 && hi < 200) begin
      @(posedge clk);
      hi++;
    end
    chk(hi == 125, "reset pulse length");
  endtask

  // main sequence
  initial begin
    rst = 1'b1; awaddr = 8'h00; araddr = 8'h00; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; wdata = 32'h0; wstrb = 4'h0;
    void'($urandom(79));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // reset state and unmapped place
    rd(swt_pkg::ADDR_STATUS, d, r);
    chk(d[1:0] === 2'b00 && r === swt_pkg::RESP_OKAY, "reset status");
    rd(swt_pkg::ADDR_IRQ_MASK, d, r);
    chk(d[1:0] === swt_pkg::IRQ_MASK_RST, "reset mask");
    wr(8'h14, 32'h1, r);
    chk(r === swt_pkg::RESP_SLVERR, "unmapped write");
    rd(8'h14, d, r);
    chk(r === swt_pkg::RESP_SLVERR && d === 32'h0, "unmapped read");
    $display("test reset done");
    // begin before initialise must fail and raise the failure event
    wr(swt_pkg::ADDR_IRQ_MASK, 32'h3, r);
    cmd(swt_pkg::CTRL_BEGIN_BIT);
    rd(swt_pkg::ADDR_STATUS, d, r);
    chk(d[swt_pkg::ST_RUN_BIT] === 1'b0 && d[swt_pkg::ST_OK_BIT] === 1'b0, "early begin");
    chk(irq === 1'b1, "fail irq");
    rd(swt_pkg::ADDR_IRQ_STAT, d, r);
    chk(d[swt_pkg::IRQ_FAIL_BIT] === 1'b1, "fail event");
    repeat (2) @(posedge clk);
    chk(irq === 1'b0, "irq after clear");
    $display("test early begin done");
    // initialise loads the default timeout in seconds
    cmd(swt_pkg::CTRL_INIT_BIT);
    cmd(swt_pkg::CTRL_BEGIN_BIT);
    rd(swt_pkg::ADDR_STATUS, d, r);
    chk(d[swt_pkg::ST_RUN_BIT] === 1'b1 && d[swt_pkg::ST_OK_BIT] === 1'b1, "begin ok");
    chk(d[31:16] === 16'h00ff || d[31:16] === 16'h00fe, "default count");
    cmd(swt_pkg::CTRL_HALT_BIT);
    $display("test default done");
    // configure with corner and random counts and units
    for (k = 0; k < 10; k++) begin
      t = (k < 4) ? ((k == 0) ? 0 : 1 + (k == 3) * 65534) : $urandom % 65536;
      u = (k < 4) ? k - 1 + (k == 0) : $urandom % 256;
      wr(swt_pkg::ADDR_CONFIG, {8'h00, u[7:0], t[15:0]}, r);
      rd(swt_pkg::ADDR_STATUS, d, r);
      chk(d[swt_pkg::ST_OK_BIT] === cfg_ok(t, u), "configure result");
    end
    rd(swt_pkg::ADDR_IRQ_STAT, d, r);
    $display("test configure done");
    // expiry timing for both units with short random counts
    for (u = 0; u < 2; u++) begin
      t = 1 + $urandom % 3;
      wr(swt_pkg::ADDR_CONFIG, {8'h00, u[7:0], t[15:0]}, r);
      cmd(swt_pkg::CTRL_BEGIN_BIT);
      expire(t, u ? CPS : CPS * SPM);
      rd(swt_pkg::ADDR_STATUS, d, r);
      chk(d[swt_pkg::ST_EXP_BIT] === 1'b1 && d[swt_pkg::ST_RUN_BIT] === 1'b0, "expired status");
      rd(swt_pkg::ADDR_IRQ_STAT, d, r);
      chk(d[swt_pkg::IRQ_EXP_BIT] === 1'b1, "expiry event");
    end
    $display("test expiry done");
    // steady reloads keep the system alive well past the timeout
    wr(swt_pkg::ADDR_CONFIG, 32'h0001_0003, r);
    cmd(swt_pkg::CTRL_BEGIN_BIT);
    rst_seen = 1'b0;
    ind_seen = 1'b0;
    ind_rises = 0;
    for (k = 0; k < 7; k++) begin
      repeat (10) @(posedge clk);
      cmd(swt_pkg::CTRL_RELOAD_BIT);
      chk(r === swt_pkg::RESP_OKAY, "reload response");
    end
    rd(swt_pkg::ADDR_STATUS, d, r);
    chk(d[swt_pkg::ST_OK_BIT] === 1'b1 && d[31:16] >= 16'h0002, "reload count");
    chk(rst_seen == 1'b0, "reset despite reloads");
    chk(ind_seen == 1'b1, "indicator still");
    chk(ind_rises >= 2, "indicator not blinking");
    // halt: no expiry and a dark indicator from here on
    cmd(swt_pkg::CTRL_HALT_BIT);
    @(posedge clk);
    ind_seen = 1'b0;
    repeat (60) @(posedge clk);
    chk(rst_seen == 1'b0 && ind_seen == 1'b0, "halt activity");
    rd(swt_pkg::ADDR_STATUS, d, r);
    chk(d[swt_pkg::ST_RUN_BIT] === 1'b0 && d[swt_pkg::ST_OK_BIT] === 1'b1, "halt status");
    $display("test reload and halt done");
    close_out;
  end

  // guard against a hang anywhere in the run
  initial begin
    repeat (100000) @(posedge clk);
    chk(1'b0, "run too long");
    close_out;
  end
endmodule // swt_watchdog_tb_top
